/* fbo_pkg.sv */
// Constants, register map and state codes for the flash bus controller
package fbo_pkg;
  // Clock and pin timing, times in ns
  localparam int CLK_PERIOD_NS = 10;
  localparam int T_SELECT_ACCESS_NS = 70;
  localparam int T_WR_SETUP_NS = 20;
  localparam int T_WR_PULSE_NS = 35;
  localparam int T_WR_HOLD_NS = 20;
  localparam int T_RESET_PULSE_NS = 500;
  localparam int T_RESET_REC_NS = 50;
  // Synchroniser latency on the data inputs
  localparam int SYNC_LAT_CYC = 3;

  // Least times round up to whole cycles
  localparam logic [7:0] SELECT_ACCESS_CYC =
    8'((T_SELECT_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] WR_SETUP_CYC =
    8'((T_WR_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] WR_PULSE_CYC =
    8'((T_WR_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] WR_HOLD_CYC =
    8'((T_WR_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] RESET_PULSE_CYC =
    8'((T_RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] RESET_REC_CYC =
    8'((T_RESET_REC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] READ_WAIT_CYC =
    8'(SELECT_ACCESS_CYC + 8'(SYNC_LAT_CYC));

  // Register offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_WDATA = 8'h08;
  localparam logic [7:0] REG_CMD = 8'h0c;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_RDATA = 8'h14;

  // Field positions
  localparam int CTRL_WORD_BIT = 0;
  localparam int CTRL_VID_BIT = 1;
  localparam int CMD_READ_BIT = 0;
  localparam int CMD_WRITE_BIT = 1;
  localparam int CMD_RESET_BIT = 2;
  localparam int CMD_PROT_BIT = 3;
  localparam int CMD_UNPROT_BIT = 4;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DONE_BIT = 1;
  localparam int STAT_RSTLOW_BIT = 2;
  localparam int PIN_A6_BIT = 6;
  localparam int PIN_A1_BIT = 1;
  localparam int PIN_A0_BIT = 0;

  // Values after reset
  localparam logic [1:0] CTRL_RESET_VAL = 2'h1;
  localparam logic [19:0] ADDR_RESET_VAL = 20'h00000;
  localparam logic [15:0] DATA_RESET_VAL = 16'h0000;

  typedef enum logic [7:0] {
    ST_IDLE = 8'h01,
    ST_RD_WAIT = 8'h02,
    ST_WR_SETUP = 8'h04,
    ST_WR_PULSE = 8'h08,
    ST_WR_HOLD = 8'h10,
    ST_RST_PULSE = 8'h20,
    ST_RST_REC = 8'h40
  } fbo_state_t;
endpackage : fbo_pkg

/* fbo_sync.sv */
// Three-stage input synchroniser with agreement flag
`timescale 1ns/1ps
module fbo_sync #(
  parameter int W = 16
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q,
  output logic stable
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;

  // First stage feeds only the second; metastability settles there
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end else begin
      s1_r <= d;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  assign q = s3_r;
  assign stable = (s2_r == s3_r);
endmodule : fbo_sync

/* fbo_ctrl.sv */
// Host-side controller driving a parallel flash over its bus pins
// Functional notes
// - Read: select low, gate low, strobe high.
// - Write: strobe and select low, gate high.
// - Write strobe stays high through reads.
// - Status readable by ordinary read cycles.
// - Protect: elevated reset, A6 low, A1 high, A0 low.
// - Unprotect: same, but A6 high.
//
// Our own choices: the strobed register port and the address map.
`timescale 1ns/1ps
module fbo_ctrl (
  input wire logic CLK,
  input wire logic RST,
  input wire logic [7:0] BUS_ADDR,
  input wire logic [31:0] BUS_WDATA,
  input wire logic BUS_WR,
  input wire logic BUS_RD,
  output logic [31:0] BUS_RDATA,
  output logic [18:0] FL_ADDR,
  input wire logic [15:0] FL_DQ_I,
  output logic [15:0] FL_DQ_O,
  output logic [15:0] FL_DQ_OE,
  output logic FL_CE_N,
  output logic FL_OE_N,
  output logic FL_WE_N,
  output logic FL_RESET_N,
  output logic FL_WORD,
  output logic FL_VID_EN
);
  fbo_pkg::fbo_state_t state_r, state_nxt;
  logic [7:0] cnt_r, cnt_nxt;
  logic [1:0] ctrl_r, ctrl_nxt;
  logic [19:0] addr_r, addr_nxt;
  logic [15:0] wdata_r, wdata_nxt;
  logic [15:0] rdata_r, rdata_nxt;
  logic done_r, done_nxt;
  logic [31:0] rd_out_r, rd_out_nxt;
  logic ce_n_r, ce_n_nxt, oe_n_r, oe_n_nxt, we_n_r, we_n_nxt;
  logic rst_n_r, rst_n_nxt, vid_r, vid_nxt;
  logic [18:0] pa_r, pa_nxt;
  logic [15:0] dq_o_r, dq_o_nxt, dq_oe_r, dq_oe_nxt;
  logic [15:0] dq_s;
  logic dq_stable;

  // Register hit decode, shared by write and read paths
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction : hit

  // Pin address: word A18:A0 from bits 19:1, protect forces A6/A1/A0
  function automatic logic [18:0] pin_addr(input logic [19:0] a,
                                           input logic prot,
                                           input logic unprot);
    logic [18:0] p;
    p = a[19:1];
    if (prot || unprot) begin
      p[fbo_pkg::PIN_A6_BIT] = unprot;
      p[fbo_pkg::PIN_A1_BIT] = 1'b1;
      p[fbo_pkg::PIN_A0_BIT] = 1'b0;
    end
    return p;
  endfunction : pin_addr

  // Byte mode leaves the upper pins floating and they never settle, so
  // each lane has its own agreement flag and only live lanes are awaited
  logic [1:0] lane_stable;
  for (genvar g = 0; g < 2; g++) begin : g_lane
    fbo_sync #(.W(8)) fbo_sync_inst (
      .CLK(CLK),
      .RST(RST),
      .d(FL_DQ_I[8*g +: 8]),
      .q(dq_s[8*g +: 8]),
      .stable(lane_stable[g])
    );
  end
  assign dq_stable = lane_stable[0] &&
                     (lane_stable[1] || !ctrl_r[fbo_pkg::CTRL_WORD_BIT]);

  ////////////////////////////////////////////////////////////////////////
  // Next-state logic: register file, sequencer and pin levels
  always_comb begin
    logic word;
    logic [15:0] drive_oe;
    word = ctrl_r[fbo_pkg::CTRL_WORD_BIT];
    // Byte mode drives only the low byte plus A-1 on the top pin
    drive_oe = word ? 16'hffff : 16'h80ff;
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    ctrl_nxt = ctrl_r;
    addr_nxt = addr_r;
    wdata_nxt = wdata_r;
    rdata_nxt = rdata_r;
    done_nxt = done_r;
    rd_out_nxt = 32'h00000000;
    ce_n_nxt = ce_n_r;
    oe_n_nxt = oe_n_r;
    we_n_nxt = we_n_r;
    rst_n_nxt = rst_n_r;
    vid_nxt = vid_r;
    pa_nxt = pa_r;
    dq_o_nxt = dq_o_r;
    dq_oe_nxt = dq_oe_r;
    // Status read clears the done flag; a completion later wins
    if (BUS_RD && hit(BUS_ADDR, fbo_pkg::REG_STATUS)) begin
      done_nxt = 1'b0;
    end
    // Bus reads answer in the following cycle only
    if (BUS_RD) begin
      unique case (BUS_ADDR)
        fbo_pkg::REG_CTRL: rd_out_nxt = {30'h00000000, ctrl_r};
        fbo_pkg::REG_ADDR: rd_out_nxt = {12'h000, addr_r};
        fbo_pkg::REG_WDATA: rd_out_nxt = {16'h0000, wdata_r};
        fbo_pkg::REG_STATUS: rd_out_nxt = {29'h00000000, !rst_n_r,
                                           done_r,
                                           state_r != fbo_pkg::ST_IDLE};
        fbo_pkg::REG_RDATA: rd_out_nxt = {16'h0000, rdata_r};
        default: rd_out_nxt = 32'h00000000;
      endcase
    end
    // Setup registers are frozen while a cycle runs so pins stay steady
    if (BUS_WR && state_r == fbo_pkg::ST_IDLE) begin
      if (hit(BUS_ADDR, fbo_pkg::REG_CTRL)) begin
        ctrl_nxt = BUS_WDATA[1:0];
      end
      if (hit(BUS_ADDR, fbo_pkg::REG_ADDR)) begin
        addr_nxt = BUS_WDATA[19:0];
      end
      if (hit(BUS_ADDR, fbo_pkg::REG_WDATA)) begin
        wdata_nxt = BUS_WDATA[15:0];
      end
    end
    unique case (state_r)
      fbo_pkg::ST_IDLE: begin
        // Standby: select high, reset high, data released
        ce_n_nxt = 1'b1;
        oe_n_nxt = 1'b1;
        we_n_nxt = 1'b1;
        dq_oe_nxt = 16'h0000;
        if (BUS_WR && hit(BUS_ADDR, fbo_pkg::REG_CMD)) begin
          pa_nxt = pin_addr(addr_r, BUS_WDATA[fbo_pkg::CMD_PROT_BIT],
                            BUS_WDATA[fbo_pkg::CMD_UNPROT_BIT]);
          dq_o_nxt = word ? wdata_r : {addr_r[0], 7'h00, wdata_r[7:0]};
          if (BUS_WDATA[fbo_pkg::CMD_RESET_BIT]) begin
            rst_n_nxt = 1'b0;
            cnt_nxt = fbo_pkg::RESET_PULSE_CYC - 8'h01;
            state_nxt = fbo_pkg::ST_RST_PULSE;
          end else if (BUS_WDATA[fbo_pkg::CMD_READ_BIT]) begin
            // Status and identification reads are plain read cycles
            ce_n_nxt = 1'b0;
            oe_n_nxt = 1'b0;
            dq_oe_nxt = word ? 16'h0000 : 16'h8000;
            cnt_nxt = fbo_pkg::READ_WAIT_CYC - 8'h01;
            state_nxt = fbo_pkg::ST_RD_WAIT;
          end else if (BUS_WDATA[fbo_pkg::CMD_WRITE_BIT] ||
                       BUS_WDATA[fbo_pkg::CMD_PROT_BIT] ||
                       BUS_WDATA[fbo_pkg::CMD_UNPROT_BIT]) begin
            // One bus write per command; software strings them together
            ce_n_nxt = 1'b0;
            dq_oe_nxt = drive_oe;
            vid_nxt = ctrl_r[fbo_pkg::CTRL_VID_BIT];
            cnt_nxt = fbo_pkg::WR_SETUP_CYC - 8'h01;
            state_nxt = fbo_pkg::ST_WR_SETUP;
          end
        end
      end
      fbo_pkg::ST_RD_WAIT: begin
        // Extra cycles cover the synchroniser; sample once stable
        if (cnt_r != 8'h00) begin
          cnt_nxt = cnt_r - 8'h01;
        end else if (dq_stable) begin
          rdata_nxt = word ? dq_s : {8'h00, dq_s[7:0]};
          ce_n_nxt = 1'b1;
          oe_n_nxt = 1'b1;
          dq_oe_nxt = 16'h0000;
          done_nxt = 1'b1;
          state_nxt = fbo_pkg::ST_IDLE;
        end
      end
      fbo_pkg::ST_WR_SETUP: begin
        // Strobe falls after select, so its fall latches the address
        if (cnt_r != 8'h00) begin
          cnt_nxt = cnt_r - 8'h01;
        end else begin
          we_n_nxt = 1'b0;
          cnt_nxt = fbo_pkg::WR_PULSE_CYC - 8'h01;
          state_nxt = fbo_pkg::ST_WR_PULSE;
        end
      end
      fbo_pkg::ST_WR_PULSE: begin
        if (cnt_r != 8'h00) begin
          cnt_nxt = cnt_r - 8'h01;
        end else begin
          we_n_nxt = 1'b1;
          cnt_nxt = fbo_pkg::WR_HOLD_CYC - 8'h01;
          state_nxt = fbo_pkg::ST_WR_HOLD;
        end
      end
      fbo_pkg::ST_WR_HOLD: begin
        // Data held past the strobe rise that latches it
        if (cnt_r != 8'h00) begin
          cnt_nxt = cnt_r - 8'h01;
        end else begin
          // Deselect is safe: the part finishes its work on its own
          ce_n_nxt = 1'b1;
          dq_oe_nxt = 16'h0000;
          vid_nxt = 1'b0;
          done_nxt = 1'b1;
          state_nxt = fbo_pkg::ST_IDLE;
        end
      end
      fbo_pkg::ST_RST_PULSE: begin
        if (cnt_r != 8'h00) begin
          cnt_nxt = cnt_r - 8'h01;
        end else begin
          rst_n_nxt = 1'b1;
          cnt_nxt = fbo_pkg::RESET_REC_CYC - 8'h01;
          state_nxt = fbo_pkg::ST_RST_REC;
        end
      end
      fbo_pkg::ST_RST_REC: begin
        // Device returns in array read; next read needs no command
        if (cnt_r != 8'h00) begin
          cnt_nxt = cnt_r - 8'h01;
        end else begin
          done_nxt = 1'b1;
          state_nxt = fbo_pkg::ST_IDLE;
        end
      end
      default: begin
        state_nxt = fbo_pkg::ST_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // State registers
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      state_r <= fbo_pkg::ST_IDLE;
      cnt_r <= 8'h00;
      ctrl_r <= fbo_pkg::CTRL_RESET_VAL;
      addr_r <= fbo_pkg::ADDR_RESET_VAL;
      wdata_r <= fbo_pkg::DATA_RESET_VAL;
      rdata_r <= fbo_pkg::DATA_RESET_VAL;
      done_r <= 1'b0;
      rd_out_r <= 32'h00000000;
      ce_n_r <= 1'b1;
      oe_n_r <= 1'b1;
      we_n_r <= 1'b1;
      rst_n_r <= 1'b1;
      vid_r <= 1'b0;
      pa_r <= 19'h00000;
      dq_o_r <= 16'h0000;
      dq_oe_r <= 16'h0000;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      ctrl_r <= ctrl_nxt;
      addr_r <= addr_nxt;
      wdata_r <= wdata_nxt;
      rdata_r <= rdata_nxt;
      done_r <= done_nxt;
      rd_out_r <= rd_out_nxt;
      ce_n_r <= ce_n_nxt;
      oe_n_r <= oe_n_nxt;
      we_n_r <= we_n_nxt;
      rst_n_r <= rst_n_nxt;
      vid_r <= vid_nxt;
      pa_r <= pa_nxt;
      dq_o_r <= dq_o_nxt;
      dq_oe_r <= dq_oe_nxt;
    end
  end

  // Outputs straight from flip-flops
  assign BUS_RDATA = rd_out_r;
  assign FL_ADDR = pa_r;
  assign FL_DQ_O = dq_o_r;
  assign FL_DQ_OE = dq_oe_r;
  assign FL_CE_N = ce_n_r;
  assign FL_OE_N = oe_n_r;
  assign FL_WE_N = we_n_r;
  assign FL_RESET_N = rst_n_r;
  assign FL_WORD = ctrl_r[fbo_pkg::CTRL_WORD_BIT];
  assign FL_VID_EN = vid_r;

  ////////////////////////////////////////////////////////////////////////
  // Checks; reset-low run length is helper state for the width check
  logic [7:0] low_run_r;
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      low_run_r <= 8'h00;
    end else begin
      low_run_r <= ce_n_r && !rst_n_r ? low_run_r + 8'h01 : 8'h00;
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  a_read_levels: assert property (
    state_r == fbo_pkg::ST_RD_WAIT |->
      !ce_n_r && !oe_n_r && we_n_r && rst_n_r)
    else $error("Read cycle pin levels wrong");
  a_write_levels: assert property (
    !we_n_r |-> !ce_n_r && oe_n_r)
    else $error("Write strobe without select or with gate low");
  a_read_strobe_high: assert property (
    !oe_n_r |-> we_n_r throughout (!oe_n_r)[*1])
    else $error("Write strobe low during read");
  a_word_drive: assert property (
    FL_WORD && !we_n_r |-> dq_oe_r == 16'hffff)
    else $error("Word write not driving all data pins");
  a_byte_float: assert property (
    !FL_WORD && !ce_n_r |-> dq_oe_r[14:8] == 7'h00 && dq_oe_r[15])
    else $error("Byte mode pin drive wrong");
  a_access_wait: assert property (
    $fell(oe_n_r) |-> (!oe_n_r)[*7])
    else $error("Read ended before select access time");
  a_standby_float: assert property (
    ce_n_r && rst_n_r && state_r == fbo_pkg::ST_IDLE |-> dq_oe_r == 16'h0)
    else $error("Data driven in standby");
  a_reset_width: assert property (
    $rose(rst_n_r) |-> low_run_r >= fbo_pkg::RESET_PULSE_CYC)
    else $error("Reset pulse too short");
  a_reset_quiet: assert property (
    !rst_n_r |-> ce_n_r && dq_oe_r == 16'h0)
    else $error("Access during reset pulse");
  a_data_hold: assert property (
    $rose(we_n_r) |-> dq_oe_r[0] && !ce_n_r ##1 dq_oe_r[0])
    else $error("Data released at strobe rise");
  a_prot_addr: assert property (
    vid_r && !we_n_r |-> pa_r[1] && !pa_r[0])
    else $error("Protect address bits wrong");

  c_read_done: cover property (state_r == fbo_pkg::ST_RD_WAIT ##1
                               state_r == fbo_pkg::ST_IDLE);
  c_write_pulse: cover property ($rose(we_n_r));
  c_reset_pulse: cover property ($rose(rst_n_r));
  c_protect: cover property (vid_r && !we_n_r);
endmodule : fbo_ctrl

/* fbo_flash_model.sv */
// Behavioural parallel flash answering the controller's pins
`timescale 1ns/1ps
module fbo_flash_model (
  input wire logic [18:0] addr,
  input wire logic [15:0] dq,
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic reset_n,
  input wire logic word,
  input wire logic vid,
  output logic [15:0] dq_o,
  output logic [15:0] dq_oe
);
  logic [15:0] mem [256];
  logic [18:0] lat_addr;
  logic [18:0] last_addr;
  logic [18:0] prot_addr;
  logic lat_lsb;
  logic sel;
  logic ok_d;
  logic wsel;
  logic [15:0] cur;
  logic [15:0] rd;
  int wr_count;
  ////////////////////////////////////////
  // Known pattern from power-up, readable with no command
  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = {~8'(i), 8'(i)};
    end
    wr_count = 0;
    prot_addr = '0;
  end
  // Reset low floats everything and ignores the cycle
  assign sel = !ce_n && !oe_n && we_n && reset_n === 1'b1;
  // Before the access time the pins show junk, not old data
  assign #(fbo_pkg::T_SELECT_ACCESS_NS) ok_d = sel;
  assign wsel = ce_n | we_n;
  assign cur = mem[addr[7:0]];
  // Byte mode uses the low lane; the top pin is the byte address
  always_comb begin
    rd = word ? cur : {8'h00, dq[15] ? cur[15:8] : cur[7:0]};
    dq_oe = !sel ? 16'h0000 : (word ? 16'hffff : 16'h00ff);
    dq_o = ok_d ? rd : ~rd;
  end
  ////////////////////////////////////////
  // Address on the later falling edge of select or strobe
  always @(negedge wsel) begin
    if (reset_n === 1'b1) begin
      lat_addr = addr;
      lat_lsb = dq[15];
    end
  end
  // Data on the earlier rising edge; elevated reset means protect
  always @(posedge wsel) begin
    if (reset_n === 1'b1 && $time > 0) begin
      last_addr = lat_addr;
      if (vid === 1'b1) begin
        prot_addr = lat_addr;
      end else begin
        wr_count++;
        if (word) mem[lat_addr[7:0]] = dq;
        else if (lat_lsb) mem[lat_addr[7:0]][15:8] = dq[7:0];
        else mem[lat_addr[7:0]][7:0] = dq[7:0];
      end
    end
  end
endmodule : fbo_flash_model

/* fbo_ctrl_tb.sv */
// Self-checking bench for the flash bus controller
`timescale 1ns/1ps
`define CHK(got, exp) \
  begin \
    compares++; \
    if ((got) !== (exp)) begin \
      fail_count++; \
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp); \
    end \
  end
module fbo_ctrl_tb;
  typedef struct {
    logic [1:0] ctrl;
    logic [19:0] addr;
    logic [15:0] wdata;
    logic [4:0] cmd;
    logic [31:0] exp;
  } fbo_row_t;
  logic clk;
  logic rst;
  logic [7:0] b_addr;
  logic [31:0] b_wdata;
  logic b_wr;
  logic b_rd;
  logic [31:0] b_rdata;
  logic [18:0] fl_addr;
  logic [15:0] dq_bus;
  logic [15:0] c_dq_o;
  logic [15:0] c_dq_oe;
  logic [15:0] m_dq_o;
  logic [15:0] m_dq_oe;
  logic ce_n;
  logic oe_n;
  logic we_n;
  logic reset_n;
  logic word;
  logic vid;
  logic [15:0] junk = 16'h5a5a;
  logic [31:0] st;
  int fail_count = 0;
  int compares = 0;
  int cycles = 0;
  int oe_len = 0;
  int rst_len = 0;
  int n0;
  fbo_row_t rows [8] = '{
    '{2'h1, 20'h00010, 16'h0000, 5'h01, 32'h0000f708},
    '{2'h0, 20'h00010, 16'h0000, 5'h01, 32'h00000008},
    '{2'h0, 20'h00011, 16'h0000, 5'h01, 32'h000000f7},
    '{2'h1, 20'h001fe, 16'h0000, 5'h01, 32'h000000ff},
    '{2'h1, 20'h00020, 16'h1234, 5'h02, 32'h00000000},
    '{2'h1, 20'h00020, 16'h0000, 5'h01, 32'h00001234},
    '{2'h0, 20'h00041, 16'h00ab, 5'h02, 32'h00000000},
    '{2'h1, 20'h00040, 16'h0000, 5'h01, 32'h0000ab20}};

  fbo_ctrl fbo_ctrl_inst (.CLK(clk), .RST(rst), .BUS_ADDR(b_addr),
    .BUS_WDATA(b_wdata), .BUS_WR(b_wr), .BUS_RD(b_rd), .BUS_RDATA(b_rdata),
    .FL_ADDR(fl_addr), .FL_DQ_I(dq_bus), .FL_DQ_O(c_dq_o),
    .FL_DQ_OE(c_dq_oe), .FL_CE_N(ce_n), .FL_OE_N(oe_n), .FL_WE_N(we_n),
    .FL_RESET_N(reset_n), .FL_WORD(word), .FL_VID_EN(vid));
  fbo_flash_model fbo_flash_model_inst (.addr(fl_addr), .dq(dq_bus),
    .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .reset_n(reset_n), .word(word),
    .vid(vid), .dq_o(m_dq_o), .dq_oe(m_dq_oe));
  ////////////////////////////////////////
  // Clock; undriven lines toggle so a stale value never passes
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) junk <= ~junk;
  // Wire level from both drivers, a floating pin shows junk
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      if (c_dq_oe[i]) dq_bus[i] = c_dq_o[i];
      else if (m_dq_oe[i]) dq_bus[i] = m_dq_o[i];
      else dq_bus[i] = junk[i];
    end
  end
  // Pin monitor and hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      fail_count++;
      end_sim();
    end
    if (rst) begin
      oe_len = 0;
      rst_len = 0;
    end else begin
      `CHK(c_dq_oe & m_dq_oe, 16'h0000);
      if (oe_n === 1'b0) begin
        oe_len++;
        `CHK({ce_n, we_n}, 2'b01);
      end else if (oe_len != 0) begin
        `CHK(oe_len >= int'(fbo_pkg::READ_WAIT_CYC), 1'b1);
        oe_len = 0;
      end
      if (we_n === 1'b0) `CHK({ce_n, oe_n}, 2'b01);
      if (vid === 1'b1) `CHK(reset_n, 1'b1);
      if (reset_n === 1'b0) rst_len++;
      else if (rst_len != 0) begin
        `CHK(8'(rst_len), fbo_pkg::RESET_PULSE_CYC);
        rst_len = 0;
      end
    end
  end
  ////////////////////////////////////////
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    b_addr <= a;
    b_wdata <= d;
    b_wr <= 1'b1;
    @(posedge clk);
    b_wr <= 1'b0;
  endtask : reg_wr
  // Read data stand only in the cycle after the strobe
  task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    b_addr <= a;
    b_rd <= 1'b1;
    @(posedge clk);
    b_rd <= 1'b0;
    @(negedge clk);
    d = b_rdata;
  endtask : reg_rd
  task automatic wait_idle();
    int n;
    n = 0;
    st = 32'h1;
    while (st[0] !== 1'b0 && n < 200) begin
      reg_rd(fbo_pkg::REG_STATUS, st);
      n++;
    end
    if (n == 200) fail_count++;
  endtask : wait_idle
  task automatic run_row(input fbo_row_t r);
    reg_wr(fbo_pkg::REG_CTRL, {30'h0, r.ctrl});
    reg_wr(fbo_pkg::REG_ADDR, {12'h000, r.addr});
    reg_wr(fbo_pkg::REG_WDATA, {16'h0000, r.wdata});
    reg_wr(fbo_pkg::REG_CMD, {27'h0, r.cmd});
    wait_idle();
    `CHK({ce_n, oe_n, we_n, c_dq_oe}, {3'b111, 16'h0000});
    if (r.cmd[0]) begin
      reg_rd(fbo_pkg::REG_RDATA, st);
      `CHK(st, r.exp);
    end else begin
      `CHK(fbo_flash_model_inst.last_addr, r.addr[19:1]);
    end
  endtask : run_row
  task automatic end_sim();
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_sim
  ////////////////////////////////////////
  // Reset, table of plain cycles, then the awkward cases
  initial begin
    rst = 1'b1;
    {b_addr, b_wdata, b_wr, b_rd} = '0;
    repeat (3) @(posedge clk);
    `CHK({ce_n, oe_n, we_n, reset_n, word, vid}, 6'h3e);
    rst <= 1'b0;
    reg_rd(fbo_pkg::REG_CTRL, st);
    `CHK(st, 32'h1);
    @(negedge clk);
    `CHK(b_rdata, 32'h00000000);
    reg_rd(8'h20, st);
    `CHK(st, 32'h0);
    foreach (rows[i]) run_row(rows[i]);
    // Commands while busy are dropped
    reg_wr(fbo_pkg::REG_CMD, 32'h1);
    reg_rd(fbo_pkg::REG_STATUS, st);
    `CHK(st[0], 1'b1);
    n0 = fbo_flash_model_inst.wr_count;
    reg_wr(fbo_pkg::REG_CMD, 32'h2);
    wait_idle();
    `CHK(fbo_flash_model_inst.wr_count, n0);
    // Protect then unprotect with elevated reset
    reg_wr(fbo_pkg::REG_CTRL, 32'h3);
    reg_wr(fbo_pkg::REG_ADDR, 32'hf0086);
    reg_rd(fbo_pkg::REG_ADDR, st);
    `CHK(st, 32'h000f0086);
    for (int i = 0; i < 2; i++) begin
      reg_wr(fbo_pkg::REG_CMD, i ? 32'h10 : 32'h08);
      wait_idle();
      st = {13'h0000, fbo_flash_model_inst.prot_addr};
      `CHK(st, i ? 32'h00078042 : 32'h00078002);
    end
    `CHK(fbo_flash_model_inst.wr_count, n0);
    // Hardware reset pulse, then array reads again
    reg_wr(fbo_pkg::REG_CMD, 32'h4);
    reg_rd(fbo_pkg::REG_STATUS, st);
    `CHK(st[2:0], 3'b101);
    wait_idle();
    run_row(rows[5]);
    // Reset in the middle of a read parks the pins
    reg_wr(fbo_pkg::REG_CTRL, 32'h0);
    reg_wr(fbo_pkg::REG_CMD, 32'h1);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    `CHK({ce_n, oe_n, c_dq_oe}, {2'b11, 16'h0000});
    rst <= 1'b0;
    run_row(rows[0]);
    end_sim();
  end
endmodule : fbo_ctrl_tb
